// *** bench/mdr_tb.sv ***
// testbench: register, detector, interrupt and capture checks of the metering result block
`timescale 1ns/1ps
`default_nettype none

module tb;
   // ------------------------------------------------------------
   // signals and instance
   // ------------------------------------------------------------
   logic                  clk;
   logic                  external_reset_pin;
   mdr_pkg::mdr_bus_req_t bus;
   logic [31:0]           rdata;
   mdr_pkg::mdr_results_t results;
   logic                  i1_sample_vld;
   logic                  calc_gate_off;
   logic                  current_seen_flag;
   logic                  irq;
   int                    bad_count;
   int                    n_compared;
   int                    cycles;
   logic [31:0]           rd_val;
   localparam int         LIMIT = 20000;

   // short timers so capture and settle happen within a few hundred clocks
   mdr_core #(
      .UPD_TICKS ('{6{24'h4}}),
      .SET_TICKS ('{6{24'h8}})
   ) DUT (
      .clk               (clk),
      .external_reset_pin              (external_reset_pin),
      .bus               (bus),
      .rdata             (rdata),
      .results           (results),
      .i1_sample_vld     (i1_sample_vld),
      .calc_gate_off     (calc_gate_off),
      .current_seen_flag (current_seen_flag),
      .irq               (irq)
   );

   // free-running clock, 20 ns period
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // hang guard: the tests need fewer than two thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         bad_count++;
         print_verdict();
      end
   end

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic check_bit(input string name, input logic exp, input logic got);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s expected %b seen %b", name, exp, got);
      end
   endtask

   // one-cycle write strobe; the bus and sample tasks start on a fresh edge
   task automatic reg_wr(input logic [15:0] idx, input logic [31:0] d);
      @(posedge clk);
      bus <= '{addr: {idx[13:0], 2'b00}, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask

   // read data only stands in the cycle after the strobe, so sample it there
   task automatic reg_rd(input logic [15:0] idx, output logic [31:0] d);
      @(posedge clk);
      bus <= '{addr: {idx[13:0], 2'b00}, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic rd_chk(input string name, input logic [15:0] idx, input logic [31:0] exp);
      reg_rd(idx, rd_val);
      check_word(name, exp, rd_val);
   endtask

   // one I1 ac sample, a single-cycle pulse
   task automatic sample(input logic [31:0] v);
      @(posedge clk);
      i1_sample_vld <= 1'b1;
      results.ac[1] <= v;
      @(posedge clk);
      i1_sample_vld <= 1'b0;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      for (int k = 0; k < mdr_pkg::NDATA; k++) begin
         rd_chk("data reset", mdr_pkg::DATA_IDX[k], 32'h0);
      end
      rd_chk("control reset", mdr_pkg::IDX_CTRL, 32'h0);
      reg_wr(16'h3000, 32'hFFFF_FFFF);
      rd_chk("unmapped", 16'h3000, 32'h0);
      check_bit("gate out", 1'b0, calc_gate_off);
      check_bit("irq reset", 1'b0, irq);
      $display("test reset done");
   endtask

   task automatic t_capture;
      // this test only reads the data and settled registers, never writes them
      @(posedge clk);
      for (int k = 0; k < mdr_pkg::NDATA; k++) begin
         results[k*32 +: 32] <= 32'hA500_0000 + 32'(k);
      end
      repeat (400) @(posedge clk);
      for (int k = 0; k < mdr_pkg::NDATA; k++) begin
         rd_chk("data capture", mdr_pkg::DATA_IDX[k], 32'hA500_0000 + 32'(k));
      end
      rd_chk("settled", mdr_pkg::IDX_SETTLED, 32'h3F);
      $display("test capture done");
   endtask

   task automatic t_detect;
      reg_wr(mdr_pkg::IDX_IRQ_MASK, 32'h1);
      reg_wr(mdr_pkg::IDX_THRESH, 32'h64);
      reg_wr(mdr_pkg::IDX_CTRL, 32'h12);
      // an equal sample is not above and breaks the run
      sample(32'h65);
      sample(32'h65);
      sample(32'h64);
      sample(32'h65);
      sample(32'h65);
      rd_chk("run broken", mdr_pkg::IDX_CTRL, 32'h12);
      sample(32'h65);
      rd_chk("caught", mdr_pkg::IDX_CTRL, 32'h52);
      check_bit("seen out", 1'b1, current_seen_flag);
      check_bit("irq up", 1'b1, irq);
      reg_rd(mdr_pkg::IDX_IRQ_STAT, rd_val);
      check_word("status set", 32'h1, rd_val & 32'h1);
      reg_rd(mdr_pkg::IDX_IRQ_STAT, rd_val);
      check_word("status read clear", 32'h0, rd_val & 32'h1);
      check_bit("irq down", 1'b0, irq);
      reg_wr(mdr_pkg::IDX_CTRL, 32'h32);
      rd_chk("clear", mdr_pkg::IDX_CTRL, 32'h32);
      reg_wr(mdr_pkg::IDX_CTRL, 32'h12);
      repeat (3) sample(32'h65);
      check_bit("seen again", 1'b1, current_seen_flag);
      // bit6 write must be ignored while disable clears the flag
      reg_wr(mdr_pkg::IDX_CTRL, 32'h42);
      rd_chk("disable", mdr_pkg::IDX_CTRL, 32'h02);
      repeat (3) sample(32'h65);
      rd_chk("disabled samples", mdr_pkg::IDX_CTRL, 32'h02);
      check_bit("seen off", 1'b0, current_seen_flag);
      $display("test detect done");
   endtask

   task automatic t_gate;
      reg_wr(mdr_pkg::IDX_CTRL, 32'h90);
      rd_chk("gate on", mdr_pkg::IDX_CTRL, 32'h90);
      check_bit("gate out on", 1'b1, calc_gate_off);
      @(posedge clk);
      results.raw[0] <= 32'h5A5A_0001;
      sample(32'h65);
      repeat (400) @(posedge clk);
      rd_chk("gated raw", mdr_pkg::DATA_IDX[0], 32'hA500_0000);
      rd_chk("gated settled", mdr_pkg::IDX_SETTLED, 32'h0);
      // run length zero: a single sample above is a catch
      reg_wr(mdr_pkg::IDX_CTRL, 32'h10);
      sample(32'h65);
      rd_chk("len zero", mdr_pkg::IDX_CTRL, 32'h50);
      check_bit("gate out off", 1'b0, calc_gate_off);
      repeat (400) @(posedge clk);
      rd_chk("ungated raw", mdr_pkg::DATA_IDX[0], 32'h5A5A_0001);
      $display("test gate done");
   endtask

   // divide by two on a 60 Hz grid: four ticks take at least 90 clocks, not 45
   task automatic t_scale;
      reg_wr(mdr_pkg::IDX_CFG, 32'h101);
      rd_chk("config", mdr_pkg::IDX_CFG, 32'h101);
      reg_wr(mdr_pkg::IDX_CTRL, 32'h80);
      results.raw[0] <= 32'h5A5A_0002;
      reg_wr(mdr_pkg::IDX_CTRL, 32'h00);
      repeat (70) @(posedge clk);
      rd_chk("scaled early", mdr_pkg::DATA_IDX[0], 32'h5A5A_0001);
      repeat (120) @(posedge clk);
      rd_chk("scaled late", mdr_pkg::DATA_IDX[0], 32'h5A5A_0002);
      $display("test scale done");
   endtask

   // reset in mid-run, with live results present
   task automatic t_rereset;
      @(posedge clk);
      external_reset_pin <= 1'b0;
      repeat (2) @(posedge clk);
      external_reset_pin <= 1'b1;
      rd_chk("raw rereset", mdr_pkg::DATA_IDX[0], 32'h0);
      rd_chk("avg rereset", mdr_pkg::DATA_IDX[19], 32'h0);
      rd_chk("cfg rereset", mdr_pkg::IDX_CFG, 32'h0);
      $display("test rereset done");
   endtask

   task automatic print_verdict;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      external_reset_pin = 1'b0;
      bus = '0;
      results = '0;
      i1_sample_vld = 1'b0;
      bad_count = 0;
      n_compared = 0;
      cycles = 0;
      repeat (16) @(posedge clk);
      external_reset_pin <= 1'b1;
      t_reset();
      t_capture();
      t_detect();
      t_gate();
      t_scale();
      t_rereset();
      print_verdict();
   end
endmodule

`default_nettype wire

// *** common/mdr_pkg.sv ***
// package: register map, timing constants and carrier types of the metering result block
package mdr_pkg;

   // ------------------------------------------------------------
   // clocks and tick generation
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ   = 50000000;
   localparam int unsigned MT_HZ    = 3276800;
   localparam int unsigned RATE_GCD = 800;
   localparam logic [16:0] MT_STEP  = 17'(MT_HZ / RATE_GCD);
   localparam logic [16:0] MT_WRAP  = 17'(CLK_HZ / RATE_GCD);
   // 60 Hz grid stretches every interval by 6/5
   localparam logic [3:0]  GRID_NUM = 4'h5;
   localparam logic [3:0]  GRID_DEN = 4'h6;
   localparam int unsigned TMR_W    = 24;
   localparam int unsigned NGRP     = 6;
   localparam int unsigned NDATA    = 20;
   localparam int unsigned ADDR_W   = 16;

   // ------------------------------------------------------------
   // update and settle times in microseconds
   // ------------------------------------------------------------
   localparam longint unsigned RAW_UPD_US = 300;
   localparam longint unsigned RAW_SET_US = 10000;
   localparam longint unsigned DC_UPD_US  = 20000;
   localparam longint unsigned DC_SET_US  = 70000;
   localparam longint unsigned AC_UPD_US  = 300;
   localparam longint unsigned AC_SET_US  = 70000;
   localparam longint unsigned PWR_UPD_US = 80000;
   localparam longint unsigned PWR_SET_US = 250000;
   localparam longint unsigned RMS_UPD_US = 10000;
   localparam longint unsigned RMS_SET_US = 100000;
   localparam longint unsigned AVG_UPD_US = 1280000;
   localparam longint unsigned AVG_SET_US = 3000000;

   // metering ticks; up rounds a least time upward
   function automatic logic [TMR_W-1:0] us_ticks(input longint unsigned us, input bit up);
      longint unsigned p;
      p = us * MT_HZ;
      if (up) p = p + 64'd999999;
      return TMR_W'(p / 64'd1000000);
   endfunction

   localparam logic [TMR_W-1:0] GRP_UPD [NGRP] = '{us_ticks(RAW_UPD_US, 1'b0), us_ticks(DC_UPD_US, 1'b0),
      us_ticks(AC_UPD_US, 1'b0), us_ticks(PWR_UPD_US, 1'b0), us_ticks(RMS_UPD_US, 1'b0), us_ticks(AVG_UPD_US, 1'b0)};
   localparam logic [TMR_W-1:0] GRP_SET [NGRP] = '{us_ticks(RAW_SET_US, 1'b1), us_ticks(DC_SET_US, 1'b1),
      us_ticks(AC_SET_US, 1'b1), us_ticks(PWR_SET_US, 1'b1), us_ticks(RMS_SET_US, 1'b1), us_ticks(AVG_SET_US, 1'b1)};
   localparam int unsigned GRP_DC  = 1;
   localparam int unsigned GRP_AVG = 5;

   // ------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [ADDR_W-1:0] DATA_IDX [NDATA] = '{16'h1005, 16'h100A, 16'h100F, 16'h103A, 16'h1041,
      16'h1048, 16'h1051, 16'h1052, 16'h1053, 16'h10D1, 16'h10D2, 16'h10D3, 16'h10D4, 16'h10D5,
      16'h10D6, 16'h10D7, 16'h10D8, 16'h10D9, 16'h10DA, 16'h10DB};
   localparam int unsigned DATA_GRP [NDATA] = '{0, 0, 0, 1, 1, 1, 2, 2, 2, 3, 3, 4, 4, 4, 5, 5, 5, 5, 5, 5};
   localparam logic [ADDR_W-1:0] IDX_CTRL     = 16'h2886;
   localparam logic [ADDR_W-1:0] IDX_THRESH   = 16'h1002;
   localparam logic [ADDR_W-1:0] IDX_CFG      = 16'h2890;
   localparam logic [ADDR_W-1:0] IDX_SETTLED  = 16'h2891;
   localparam logic [ADDR_W-1:0] IDX_IRQ_STAT = 16'h2892;
   localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = 16'h2893;

   // control register fields and reset values
   localparam int unsigned BIT_GATE  = 7;
   localparam int unsigned BIT_SEEN  = 6;
   localparam int unsigned BIT_CLR   = 5;
   localparam int unsigned BIT_EN    = 4;
   localparam int unsigned LEN_W     = 4;
   localparam int unsigned BIT_GRID  = 8;
   localparam int unsigned KDIV_W    = 8;
   localparam logic [31:0] THR_RST   = 32'h0000_0000;
   localparam int unsigned NIRQ      = 3;
   localparam int unsigned IRQ_SEEN  = 0;
   localparam int unsigned IRQ_AVG   = 1;
   localparam int unsigned IRQ_SETL  = 2;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic [5:0][31:0] avg;
      logic [2:0][31:0] rmsi;
      logic [1:0][31:0] pinst;
      logic [2:0][31:0] ac;
      logic [2:0][31:0] dc;
      logic [2:0][31:0] raw;
   } mdr_results_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [31:0]       wdata;
      logic              wr;
      logic              rd;
   } mdr_bus_req_t;

endpackage

// *** src/mdr_core.sv ***
// metering result registers with current-presence detector
//
// Behaviour
// - gate bit stops sampling and the update and settle timers of all six groups, averages included
// - detection sets the read-only seen flag; held until clear or disable
// - detection runs only while enabled; writing zero disables and clears flag
// - run length plus one consecutive I1 ac samples above threshold means caught
// - every reset returns all data registers to zero
// - intervals are at 3.2768 MHz metering clock; divide by K scales by K
// - a 60 Hz grid stretches every interval by 1.2
// - raw waveforms refresh every 0.3 ms, valid after 10 ms
// - dc components refresh every 20 ms, settled after 70 ms
// - ac components refresh every 0.3 ms, settled after 70 ms
// - instantaneous path powers refresh every 80 ms, settled after 250 ms
// - instantaneous rms refresh every 10 ms, settled after 100 ms
// - averages and apparent power refresh every 1.28 s, settled after 3 s
`timescale 1ns/1ps
`default_nettype none

module mdr_core #(
   parameter logic [mdr_pkg::TMR_W-1:0] UPD_TICKS [mdr_pkg::NGRP] = mdr_pkg::GRP_UPD,
   parameter logic [mdr_pkg::TMR_W-1:0] SET_TICKS [mdr_pkg::NGRP] = mdr_pkg::GRP_SET
) (
   input  wire logic                  clk,
   input  wire logic                  external_reset_pin,
   input  wire mdr_pkg::mdr_bus_req_t bus,
   output logic [31:0]                rdata,
   input  wire mdr_pkg::mdr_results_t results,
   input  wire logic                  i1_sample_vld,
   output logic                       calc_gate_off,
   output logic                       current_seen_flag,
   output logic                       irq
);

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   function automatic logic at(input logic [mdr_pkg::ADDR_W-1:0] a, input logic [mdr_pkg::ADDR_W-1:0] idx);
      return a == {idx[mdr_pkg::ADDR_W-3:0], 2'b00};
   endfunction

   logic                     hit_ctrl;
   logic                     hit_thr;
   logic                     hit_cfg;
   logic                     hit_setl;
   logic                     hit_ist;
   logic                     hit_imsk;
   logic [mdr_pkg::NDATA-1:0] hit_data;
   logic [mdr_pkg::NDATA-1:0][31:0] res_w;

   // decode is exact: any other word is unmapped and reads zero
   assign hit_ctrl = at(bus.addr, mdr_pkg::IDX_CTRL);
   assign hit_thr  = at(bus.addr, mdr_pkg::IDX_THRESH);
   assign hit_cfg  = at(bus.addr, mdr_pkg::IDX_CFG);
   assign hit_setl = at(bus.addr, mdr_pkg::IDX_SETTLED);
   assign hit_ist  = at(bus.addr, mdr_pkg::IDX_IRQ_STAT);
   assign hit_imsk = at(bus.addr, mdr_pkg::IDX_IRQ_MASK);
   assign res_w    = results;

   // ------------------------------------------------------------
   // control, threshold and configuration registers
   // ------------------------------------------------------------
   logic                        gate_r;
   logic                        clr_r;
   logic                        en_r;
   logic [mdr_pkg::LEN_W-1:0]   len_r;
   logic [31:0]                 thr_r;
   logic                        grid60_r;
   logic [mdr_pkg::KDIV_W-1:0]  kdiv_r;
   logic                        wr_ctrl;

   assign wr_ctrl = bus.wr && hit_ctrl;

   // writable control bits; the seen flag is read-only and lives below
   always_ff @(posedge clk or negedge external_reset_pin) begin
      if (!external_reset_pin) begin
         gate_r <= 1'b0;
         clr_r  <= 1'b0;
         en_r   <= 1'b0;
         len_r  <= '0;
      end else if (wr_ctrl) begin
         gate_r <= bus.wdata[mdr_pkg::BIT_GATE];
         clr_r  <= bus.wdata[mdr_pkg::BIT_CLR];
         en_r   <= bus.wdata[mdr_pkg::BIT_EN];
         len_r  <= bus.wdata[mdr_pkg::LEN_W-1:0];
      end
   end

   // threshold, clock divider and grid selection
   always_ff @(posedge clk or negedge external_reset_pin) begin
      if (!external_reset_pin) begin
         thr_r    <= mdr_pkg::THR_RST;
         grid60_r <= 1'b0;
         kdiv_r   <= '0;
      end else begin
         if (bus.wr && hit_thr) thr_r <= bus.wdata;
         if (bus.wr && hit_cfg) begin
            grid60_r <= bus.wdata[mdr_pkg::BIT_GRID];
            kdiv_r   <= bus.wdata[mdr_pkg::KDIV_W-1:0];
         end
      end
   end

   // ------------------------------------------------------------
   // current detection
   // ------------------------------------------------------------
   logic                      samp;
   logic                      above;
   logic                      caught;
   logic                      seen_r;
   logic [mdr_pkg::LEN_W-1:0] run_r;
   logic                      clr_req;

   // gated sampling delivers no samples to the detector
   assign samp    = i1_sample_vld && !gate_r && en_r;
   assign above   = $signed(res_w[7]) > $signed(thr_r);
   assign caught  = samp && above && (run_r >= len_r);
   assign clr_req = wr_ctrl && bus.wdata[mdr_pkg::BIT_CLR];

   // consecutive counter saturates at the run length
   always_ff @(posedge clk or negedge external_reset_pin) begin
      if (!external_reset_pin) begin
         run_r <= '0;
      end else if (!en_r) begin
         run_r <= '0;
      end else if (samp) begin
         if (!above) run_r <= '0;
         else if (run_r < len_r) run_r <= run_r + 1'b1;
      end
   end

   // a catch in the cycle of a clear or disable write still wins
   always_ff @(posedge clk or negedge external_reset_pin) begin
      if (!external_reset_pin) begin
         seen_r <= 1'b0;
      end else if (caught) begin
         seen_r <= 1'b1;
      end else if (clr_req || !en_r || (wr_ctrl && !bus.wdata[mdr_pkg::BIT_EN])) begin
         seen_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // metering tick: 3.2768 MHz from 50 MHz, then divide and grid
   // ------------------------------------------------------------
   logic [16:0]                ph_r;
   logic [16:0]                ph_sum;
   logic                       base_tk_r;
   logic [mdr_pkg::KDIV_W-1:0] kcnt_r;
   logic                       k_tk_r;
   logic [3:0]                 gacc_r;
   logic [3:0]                 gsum;
   logic                       mt_tk_r;

   assign ph_sum = ph_r + mdr_pkg::MT_STEP;
   assign gsum   = gacc_r + mdr_pkg::GRID_NUM;

   // fractional accumulator keeps the long-run rate exact
   always_ff @(posedge clk or negedge external_reset_pin) begin
      if (!external_reset_pin) begin
         ph_r      <= '0;
         base_tk_r <= 1'b0;
      end else if (ph_sum >= mdr_pkg::MT_WRAP) begin
         ph_r      <= ph_sum - mdr_pkg::MT_WRAP;
         base_tk_r <= 1'b1;
      end else begin
         ph_r      <= ph_sum;
         base_tk_r <= 1'b0;
      end
   end

   // divide by K = kdiv + 1 scales every interval by K
   always_ff @(posedge clk or negedge external_reset_pin) begin
      if (!external_reset_pin) begin
         kcnt_r <= '0;
         k_tk_r <= 1'b0;
      end else begin
         k_tk_r <= base_tk_r && (kcnt_r >= kdiv_r);
         if (base_tk_r) kcnt_r <= (kcnt_r >= kdiv_r) ? '0 : kcnt_r + 1'b1;
      end
   end

   // on 60 Hz keep five ticks of six, so intervals stretch by 1.2
   always_ff @(posedge clk or negedge external_reset_pin) begin
      if (!external_reset_pin) begin
         gacc_r  <= '0;
         mt_tk_r <= 1'b0;
      end else if (!grid60_r) begin
         gacc_r  <= '0;
         mt_tk_r <= k_tk_r;
      end else if (k_tk_r) begin
         mt_tk_r <= gsum >= mdr_pkg::GRID_DEN;
         gacc_r  <= (gsum >= mdr_pkg::GRID_DEN) ? gsum - mdr_pkg::GRID_DEN : gsum;
      end else begin
         mt_tk_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // per-group update and settle timers
   // ------------------------------------------------------------
   logic [mdr_pkg::TMR_W-1:0] upd_cnt_r [mdr_pkg::NGRP];
   logic [mdr_pkg::TMR_W-1:0] set_cnt_r [mdr_pkg::NGRP];
   logic [mdr_pkg::NGRP-1:0]  upd_stb;
   logic [mdr_pkg::NGRP-1:0]  settled;

   // gating clears the timers; settling restarts once sampling resumes
   for (genvar g = 0; g < mdr_pkg::NGRP; g++) begin : g_grp
      always_ff @(posedge clk or negedge external_reset_pin) begin
         if (!external_reset_pin) begin
            upd_cnt_r[g] <= '0;
            set_cnt_r[g] <= '0;
         end else if (gate_r) begin
            upd_cnt_r[g] <= '0;
            set_cnt_r[g] <= '0;
         end else if (mt_tk_r) begin
            upd_cnt_r[g] <= upd_stb[g] ? '0 : upd_cnt_r[g] + 1'b1;
            if (!settled[g]) set_cnt_r[g] <= set_cnt_r[g] + 1'b1;
         end
      end
      assign upd_stb[g] = mt_tk_r && !gate_r && (upd_cnt_r[g] == UPD_TICKS[g] - 1'b1);
      assign settled[g] = set_cnt_r[g] >= SET_TICKS[g];
   end

   // ------------------------------------------------------------
   // result registers
   // ------------------------------------------------------------
   logic [31:0] data_r [mdr_pkg::NDATA];

   // a bus write wins over a capture in the same cycle
   for (genvar w = 0; w < mdr_pkg::NDATA; w++) begin : g_data
      assign hit_data[w] = at(bus.addr, mdr_pkg::DATA_IDX[w]);
      always_ff @(posedge clk or negedge external_reset_pin) begin
         if (!external_reset_pin) begin
            data_r[w] <= '0;
         end else if (bus.wr && hit_data[w]) begin
            data_r[w] <= bus.wdata;
         end else if (upd_stb[mdr_pkg::DATA_GRP[w]]) begin
            data_r[w] <= res_w[w];
         end
      end
   end

   // ------------------------------------------------------------
   // interrupts
   // ------------------------------------------------------------
   logic [mdr_pkg::NIRQ-1:0] ist_r;
   logic [mdr_pkg::NIRQ-1:0] imsk_r;
   logic [mdr_pkg::NIRQ-1:0] ev;
   logic                     all_setl_r;
   logic                     irq_r;

   assign ev = {(&settled) && !all_setl_r, upd_stb[mdr_pkg::GRP_AVG], caught};

   // read clears status; a fresh event in that cycle survives
   always_ff @(posedge clk or negedge external_reset_pin) begin
      if (!external_reset_pin) begin
         ist_r      <= '0;
         imsk_r     <= '0;
         all_setl_r <= 1'b0;
         irq_r      <= 1'b0;
      end else begin
         ist_r      <= ((bus.rd && hit_ist) ? '0 : ist_r) | ev;
         if (bus.wr && hit_imsk) imsk_r <= bus.wdata[mdr_pkg::NIRQ-1:0];
         all_setl_r <= &settled;
         irq_r      <= |(ist_r & imsk_r);
      end
   end

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   logic [31:0] rd_nxt;
   logic [31:0] rdata_r;

   always_comb begin
      rd_nxt = '0;
      if (hit_ctrl) rd_nxt = {24'h00_0000, gate_r, seen_r, clr_r, en_r, len_r};
      if (hit_thr)  rd_nxt = thr_r;
      if (hit_cfg)  rd_nxt = {23'h00_0000, grid60_r, kdiv_r};
      if (hit_setl) rd_nxt = {26'h000_0000, settled};
      if (hit_ist)  rd_nxt = {29'h0000_0000, ist_r};
      if (hit_imsk) rd_nxt = {29'h0000_0000, imsk_r};
      for (int i = 0; i < mdr_pkg::NDATA; i++) begin
         if (hit_data[i]) rd_nxt = data_r[i];
      end
   end

   // data stand only in the cycle after the read strobe
   always_ff @(posedge clk or negedge external_reset_pin) begin
      if (!external_reset_pin) rdata_r <= '0;
      else rdata_r <= bus.rd ? rd_nxt : '0;
   end

   assign rdata             = rdata_r;
   assign calc_gate_off     = gate_r;
   assign current_seen_flag = seen_r;
   assign irq               = irq_r;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!external_reset_pin);

   sequence s_hit_run;
      samp && above && run_r == len_r;
   endsequence

   sequence s_gated;
      gate_r ##1 gate_r;
   endsequence

   sequence s_clear_wr;
      wr_ctrl && bus.wdata[mdr_pkg::BIT_CLR] && !caught;
   endsequence

   a_gate_freezes_updates: assert property (s_gated |-> upd_stb == '0 && settled == '0)
      else $error("update or settled while gated");
   a_catch_sets_flag: assert property (s_hit_run |=> seen_r && current_seen_flag)
      else $error("flag not set after full run");
   a_flag_holds: assert property (seen_r && en_r && !wr_ctrl |=> seen_r)
      else $error("flag dropped without clear");
   a_disable_clears: assert property (!en_r |=> !seen_r ##0 run_r == '0)
      else $error("flag or counter alive while disabled");
   a_rise_needs_run: assert property ($rose(seen_r) |-> $past(samp) && $past(above) && $past(run_r) >= $past(len_r))
      else $error("flag rose without a full run");
   a_miss_restarts: assert property (samp && !above |=> run_r == '0)
      else $error("counter kept after a low sample");
   a_tick_spacing: assert property (mt_tk_r |=> (!mt_tk_r)[*8])
      else $error("metering ticks too close");
   a_grid_drop: assert property (k_tk_r && grid60_r && gacc_r == '0 |=> !mt_tk_r ##0 gacc_r == mdr_pkg::GRID_NUM)
      else $error("60 Hz tick not dropped");
   a_dc_capture: assert property (upd_stb[mdr_pkg::GRP_DC] && !bus.wr |=> data_r[3] == $past(res_w[3]))
      else $error("dc word not captured");
   a_read_timing: assert property (bus.rd && hit_ctrl |=> rdata[6] == $past(seen_r) ##1 bus.rd || rdata == '0)
      else $error("read data misplaced");
   a_irq_level: assert property ((ist_r & imsk_r) != '0 |=> irq)
      else $error("unmasked status without interrupt");

   // flag, counter, tick scaling, settle and capture details
   a_clear_drops: assert property (s_clear_wr |=> !seen_r)
      else $error("clear write left the flag set");
   a_flag_readonly: assert property (wr_ctrl && !seen_r && !caught |=> !seen_r)
      else $error("flag set by a control write");
   a_len_zero_catch: assert property (samp && above && len_r == '0 |=> seen_r)
      else $error("single sample not caught at run length zero");
   a_count_up: assert property (samp && above && run_r < len_r |=> run_r == $past(run_r) + 1'b1)
      else $error("run counter did not advance");
   a_kdiv_skip: assert property (base_tk_r && kcnt_r < kdiv_r |=> !k_tk_r)
      else $error("divided tick not skipped");
   a_kdiv_pass: assert property (base_tk_r && kcnt_r >= kdiv_r |=> k_tk_r)
      else $error("divided tick missing");
   a_grid_keep: assert property (k_tk_r && grid60_r && gacc_r != '0 |=> mt_tk_r)
      else $error("60 Hz tick dropped out of turn");
   a_grid_off: assert property (k_tk_r && !grid60_r |=> mt_tk_r)
      else $error("50 Hz tick lost");
   a_settle_holds: assert property (settled[mdr_pkg::GRP_AVG] && !gate_r |=> settled[mdr_pkg::GRP_AVG])
      else $error("settled bit fell without gating");
   a_raw_capture: assert property (upd_stb[0] && !bus.wr |=> data_r[1] == $past(res_w[1]))
      else $error("raw word not captured");
   a_gated_hold: assert property (gate_r && !bus.wr |=> $stable(data_r[0]))
      else $error("result changed while gated");

endmodule

`default_nettype wire
